// ---- core/spi_pkg.sv ----
/*
  constants shared by the serial port: register byte addresses, field
  positions, reset values, divider half periods and pin indexes.
  assumes a 32-bit apb slave with byte addresses on paddr[7:0].
*/
package spi_pkg;
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_PIN_DIR = 8'h0c;

  localparam int CTL_IRQ_EN = 7;
  localparam int CTL_ENABLE = 6;
  localparam int CTL_ORDER = 5;
  localparam int CTL_MASTER = 4;
  localparam int CTL_CLOCK_POLARITY = 3;
  localparam int CTL_CLOCK_PHASE = 2;
  localparam int CTL_RATE_HI = 1;
  localparam int CTL_RATE_LO = 0;

  localparam int STS_DONE = 7;
  localparam int STS_WRITE_COLLISION_FLAG = 6;
  localparam int STS_DOUBLE = 0;

  localparam int DIR_MOSI = 0;
  localparam int DIR_MISO = 1;
  localparam int DIR_SCK = 2;
  localparam int DIR_SS = 3;
  localparam int DIR_SS_LEVEL = 4;

  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [4:0] PIN_DIR_RST = 5'h10;

  localparam int PIN_SCK = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_MISO = 2;
  localparam int PIN_SS = 3;
  localparam logic [3:0] PIN_SYNC_RST = 4'h8;

  // sck half period in mclk cycles, index {double_rate, rate_hi, rate_lo}
  localparam logic [6:0] HALF_CYC [0:7] = '{7'h02, 7'h08, 7'h20, 7'h40,
                                           7'h01, 7'h04, 7'h10, 7'h20};
  localparam logic [4:0] LAST_EDGE = 5'h0f;
  localparam logic [3:0] LAST_BIT = 4'h7;

  typedef enum logic [0:0] {M_IDLE, M_RUN} master_state_t;
endpackage

// ---- core/spi_pin_sync.sv ----
/*
  three-stage synchroniser for the serial pins; the output follows once
  the second and third stages agree.
  assumes pins are asynchronous to mclk.
*/
`timescale 1ns/100ps
module spi_pin_sync (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [3:0] pins_in,
  output logic [3:0] pins_out
);
  import spi_pkg::*;
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [3:0] s3_r;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= PIN_SYNC_RST;
      s2_r <= PIN_SYNC_RST;
      s3_r <= PIN_SYNC_RST;
    end else begin
      s1_r <= pins_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // per bit: accept only a settled level
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_bit
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          pins_out[i] <= PIN_SYNC_RST[i];
        end else if (s2_r[i] == s3_r[i]) begin
          pins_out[i] <= s3_r[i];
        end
      end
    end
  endgenerate
endmodule

// ---- core/spi_clk_div.sv ----
/*
  master sck rate divider: one-cycle tick per sck half period.
  assumes run is low between transfers so each byte starts a full half period.
*/
`timescale 1ns/100ps
module spi_clk_div (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic run,
  input wire logic [2:0] rate_sel,
  output logic tick
);
  import spi_pkg::*;
  logic [6:0] cnt_r;
  logic [6:0] half;

  assign half = HALF_CYC[rate_sel];
  assign tick = run && (cnt_r == half - 7'h01);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 7'h00;
    end else if (!run || tick) begin
      cnt_r <= 7'h00;
    end else begin
      cnt_r <= cnt_r + 7'h01;
    end
  end
endmodule

// ---- core/spi_port.sv ----
/*
  byte-wide serial peripheral port, master or slave, with apb registers:
  control, status, data and pin direction.
  assumes the pad ring resolves the *_o/*_oe pairs, and that gie comes from
  the cpu status word and irq_ack pulses when the port vector executes.
*/
// Operation
// - slave with select low is active, miso driven only if configured output
// - select rising in slave resets bit counter and drops partial shift data
// - master with select as output: pin is plain output, no effect
// - master with select input low clears master select, becomes slave
// - loss of master also sets done flag and may raise interrupt
// - master select stays cleared until software sets it again
// - irq enable bit 7 requests interrupt when done flag and gie set
// - enable bit 6 gates every transfer
// - bit order bit 5: one sends lsb first, zero msb first
// - polarity bit 3 sets sck idle level and leading edge direction
// - phase zero samples leading edge, phase one samples trailing edge
// - master sck is mclk over 4,16,64,128 or 2,8,32,64 with double
// - rate bits have no effect in slave mode
// - status bit 7 done flag sets when a byte transfer finishes
// - done clears on vector ack, or status read then data access
// - data write during transfer sets collision flag, cleared by status read then data access
// - status bits 5 to 1 read zero
// - status bit 0 doubles master sck, shortest period two mclk cycles
// - data write starts transmission, read returns receive buffer
// - shift out and latch in on opposite edges, modes 0 to 3
// - master data write runs clock for eight bits, stops, sets done
// - single buffered transmit, double buffered receive, overrun overwrites
// - slave forces mosi, sck, select input; master forces miso input
`timescale 1ns/100ps
module spi_port (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic gie,
  input wire logic irq_ack,
  output logic port_irq,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic ss_n_i,
  output logic ss_n_o,
  output logic ss_n_oe
);
  import spi_pkg::*;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ADDR_CONTROL) || (a == ADDR_STATUS) ||
             (a == ADDR_DATA) || (a == ADDR_PIN_DIR);
  endfunction

  logic [7:0] ctrl_r;
  logic dbl_r;
  logic [4:0] pin_dir_r;
  logic done_r;
  logic write_collision_flag_r;
  logic arm_done_r;
  logic arm_write_collision_flag_r;
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic [7:0] rxbuf_r;
  logic [3:0] bit_cnt_r;
  logic [4:0] edge_cnt_r;
  master_state_t mstate_r;
  logic sck_r;
  logic sck_prev_r;
  logic [31:0] prdata_r;
  logic [3:0] pins_s;
  logic tick;

  logic setup_ph;
  logic acc;
  logic wr;
  logic rd;
  logic data_acc;
  logic dwr;
  logic enable;
  logic is_master;
  logic is_slave;
  logic slave_sel;
  logic loss;
  logic clock_polarity;
  logic clock_phase;
  logic order;
  logic m_edge;
  logic m_end;
  logic lead;
  logic trail;
  logic sample_ev;
  logic setup_ev;
  logic in_bit;
  logic out_bit;
  logic [7:0] rx_nxt;
  logic byte_end;
  logic busy;
  logic start;
  logic done_set;
  logic s_chg;

  // about four cycles of pin latency; a fast far-side master sees late miso
  // all four pins pass the synchroniser; slave sck is sampled, not a clock
  spi_pin_sync u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .pins_in({ss_n_i, miso_i, mosi_i, sck_i}),
    .pins_out(pins_s)
  );

  // divider held cleared between bytes, so the first half period is full
  spi_clk_div u_div (
    .mclk(mclk),
    .rstn(rstn),
    .run(mstate_r == M_RUN),
    .rate_sel({dbl_r, ctrl_r[CTL_RATE_HI], ctrl_r[CTL_RATE_LO]}),
    .tick(tick)
  );

  assign setup_ph = psel && !penable;
  assign acc = psel && penable;
  assign wr = acc && pwrite && mapped(paddr);
  assign rd = acc && !pwrite && mapped(paddr);
  assign data_acc = acc && (paddr == ADDR_DATA);
  assign dwr = wr && (paddr == ADDR_DATA);
  assign pready = 1'b1;
  assign pslverr = acc && !mapped(paddr);
  assign prdata = prdata_r;

  assign enable = ctrl_r[CTL_ENABLE];
  assign is_master = enable && ctrl_r[CTL_MASTER];
  assign is_slave = enable && !ctrl_r[CTL_MASTER];
  assign slave_sel = is_slave && !pins_s[PIN_SS];
  // select as output is never looked at by the port
  assign loss = is_master && !pin_dir_r[DIR_SS] && !pins_s[PIN_SS];
  assign clock_polarity = ctrl_r[CTL_CLOCK_POLARITY];
  assign clock_phase = ctrl_r[CTL_CLOCK_PHASE];
  assign order = ctrl_r[CTL_ORDER];

  // master edges: even index leading, odd trailing
  assign m_edge = (mstate_r == M_RUN) && tick;
  assign m_end = m_edge && (edge_cnt_r == LAST_EDGE);
  // slave edges from the settled sck; rate bits play no part here
  assign s_chg = slave_sel && (pins_s[PIN_SCK] != sck_prev_r);
  assign lead = is_master ? (m_edge && !edge_cnt_r[0])
                          : (s_chg && (pins_s[PIN_SCK] != clock_polarity));
  assign trail = is_master ? (m_edge && edge_cnt_r[0])
                           : (s_chg && (pins_s[PIN_SCK] == clock_polarity));
  assign sample_ev = clock_phase ? trail : lead;
  assign setup_ev = clock_phase ? lead : trail;

  assign in_bit = is_master ? pins_s[PIN_MISO] : pins_s[PIN_MOSI];
  assign out_bit = order ? tx_r[0] : tx_r[7];
  assign rx_nxt = order ? {in_bit, rx_r[7:1]} : {rx_r[6:0], in_bit};
  assign byte_end = sample_ev && (bit_cnt_r == LAST_BIT);

  // slave busy only once a bit is in, so tx may be reloaded between bytes
  assign busy = is_master ? (mstate_r == M_RUN) : (slave_sel && bit_cnt_r != 4'h0);
  assign start = dwr && is_master && (mstate_r == M_IDLE);
  assign done_set = (is_slave ? byte_end : m_end) || loss;

  // control: software owns every bit, loss of master overrides a write
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= CONTROL_RST;
    end else begin
      if (wr && paddr == ADDR_CONTROL) begin
        ctrl_r <= pwdata[7:0];
      end
      if (loss) begin
        ctrl_r[CTL_MASTER] <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dbl_r <= 1'b0;
      pin_dir_r <= PIN_DIR_RST;
    end else begin
      if (wr && paddr == ADDR_STATUS) begin
        dbl_r <= pwdata[STS_DOUBLE];
      end
      if (wr && paddr == ADDR_PIN_DIR) begin
        pin_dir_r <= pwdata[4:0];
      end
    end
  end

  // flags: a set in the clearing cycle wins
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      done_r <= 1'b0;
      write_collision_flag_r <= 1'b0;
      arm_done_r <= 1'b0;
      arm_write_collision_flag_r <= 1'b0;
    end else begin
      if (done_set) begin
        done_r <= 1'b1;
      end else if ((data_acc && arm_done_r) || (data_acc && arm_write_collision_flag_r) || irq_ack) begin
        done_r <= 1'b0;
      end
      if (dwr && busy) begin
        write_collision_flag_r <= 1'b1;
      end else if (data_acc && arm_write_collision_flag_r) begin
        write_collision_flag_r <= 1'b0;
      end
      // snapshot dropped by any data access or a vector ack
      if (rd && paddr == ADDR_STATUS) begin
        arm_done_r <= done_r;
        arm_write_collision_flag_r <= write_collision_flag_r;
      end else if (data_acc || irq_ack) begin
        arm_done_r <= 1'b0;
        arm_write_collision_flag_r <= 1'b0;
      end
    end
  end

  // master sequencer; dropping enable or master aborts the byte
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mstate_r <= M_IDLE;
      edge_cnt_r <= 5'h00;
    end else begin
      case (mstate_r)
        M_IDLE: begin
          edge_cnt_r <= 5'h00;
          if (start) begin
            mstate_r <= M_RUN;
          end
        end
        M_RUN: begin
          if (!is_master || m_end) begin
            mstate_r <= M_IDLE;
            edge_cnt_r <= 5'h00;
          end else if (m_edge) begin
            edge_cnt_r <= edge_cnt_r + 5'h01;
          end
        end
        default: mstate_r <= M_IDLE;
      endcase
    end
  end

  // master sck: idle at polarity level, toggles each half period
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sck_r <= 1'b0;
    end else if (mstate_r != M_RUN) begin
      sck_r <= clock_polarity;
    end else if (m_edge) begin
      sck_r <= !sck_r;
    end
  end

  // resets low like the synchronised sck, so no false edge after reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sck_prev_r <= 1'b0;
    end else begin
      sck_prev_r <= pins_s[PIN_SCK];
    end
  end

  // bit counter and receive shifter; inactive slave holds them cleared
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_r <= 4'h0;
      rx_r <= DATA_RST;
    end else if ((!slave_sel && !is_master) || (is_master && mstate_r == M_IDLE)) begin
      bit_cnt_r <= 4'h0;
      rx_r <= DATA_RST;
    end else if (sample_ev) begin
      rx_r <= rx_nxt;
      bit_cnt_r <= byte_end ? 4'h0 : bit_cnt_r + 4'h1;
    end
  end

  // receive buffer is overwritten by each finished byte, read or not
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rxbuf_r <= DATA_RST;
    end else if (byte_end) begin
      rxbuf_r <= rx_nxt;
    end
  end

  // single transmit register: loaded only between bytes, shifted on
  // setup edges; count zero skips the shift before the first sample
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tx_r <= DATA_RST;
    end else if (dwr && !busy) begin
      tx_r <= pwdata[7:0];
    end else if (setup_ev && bit_cnt_r != 4'h0) begin
      tx_r <= order ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
    end
  end

  // read data latched in the setup phase, stable through the access
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_ph) begin
      if (paddr == ADDR_CONTROL) begin
        prdata_r <= {24'h000000, ctrl_r};
      end else if (paddr == ADDR_STATUS) begin
        prdata_r <= {24'h000000, done_r, write_collision_flag_r, 5'h00, dbl_r};
      end else if (paddr == ADDR_DATA) begin
        prdata_r <= {24'h000000, rxbuf_r};
      end else if (paddr == ADDR_PIN_DIR) begin
        prdata_r <= {27'h0000000, pin_dir_r};
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  // level request; falls when the done flag, irq enable bit 7 or gie goes low
  assign port_irq = ctrl_r[CTL_IRQ_EN] && done_r && gie;

  // pin overrides: slave leaves mosi, sck, select as inputs
  assign sck_o = sck_r;
  assign sck_oe = is_master && pin_dir_r[DIR_SCK];
  assign mosi_o = out_bit;
  assign mosi_oe = is_master && pin_dir_r[DIR_MOSI];
  assign miso_o = out_bit;
  assign miso_oe = slave_sel && pin_dir_r[DIR_MISO];
  assign ss_n_o = pin_dir_r[DIR_SS_LEVEL];
  assign ss_n_oe = is_master && pin_dir_r[DIR_SS];
endmodule

// ---- sim/spi_port_props.sv ----
/* assertions on the serial port's apb and pin side.
   assumes it is bound onto spi_port and sees only its ports. */
`timescale 1ns/100ps
module spi_port_props
  import spi_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pslverr,
  input wire logic gie,
  input wire logic irq_ack,
  input wire logic port_irq,
  input wire logic sck_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic ss_n_i,
  input wire logic ss_n_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // select held low against a master with select as input
  sequence s_ss_pulled;
    sck_oe && !ss_n_oe && !ss_n_i ##1 (!ss_n_i && !ss_n_oe) [*6];
  endsequence
  a_irq_gated: assert property (port_irq |-> gie)
    else $error("interrupt without global enable");
  a_ack_clears: assert property (port_irq && irq_ack |=> !port_irq)
    else $error("interrupt kept after vector ack");
  a_role_exclusive: assert property (miso_oe |-> !sck_oe && !mosi_oe)
    else $error("slave and master drivers on together");
  a_ss_idle_miso: assert property (ss_n_i [*5] |-> !miso_oe)
    else $error("miso driven while not selected");
  a_master_lost: assert property (s_ss_pulled |=> !sck_oe)
    else $error("master kept driving after select pulled low");
  a_ss_output_free: assert property (sck_oe && ss_n_oe && !psel |=> sck_oe)
    else $error("select output disturbed master role");
  a_master_sw_only: assert property ($rose(sck_oe) |-> $past(penable) && $past(pwrite))
    else $error("master role returned without a write");
  a_unmapped_err: assert property (psel && penable && paddr > ADDR_PIN_DIR |-> pslverr)
    else $error("no error on unmapped address");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
endmodule

bind spi_port spi_port_props u_spi_port_props (.mclk(mclk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pslverr(pslverr), .gie(gie),
  .irq_ack(irq_ack), .port_irq(port_irq), .sck_oe(sck_oe), .mosi_oe(mosi_oe),
  .miso_oe(miso_oe), .ss_n_i(ss_n_i), .ss_n_oe(ss_n_oe));

// ---- sim/spi_partner.sv ----
/* far-side slave: shifts a byte out on miso, collects the byte on mosi.
   assumes mode and bit order are set before select falls. */
`timescale 1ns/100ps
module spi_partner (
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic clock_polarity,
  input wire logic clock_phase,
  input wire logic lsb,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  logic [7:0] sh;
  int n;
  function automatic logic pick(input int k);
    return lsb ? tx[k] : tx[7 - k];
  endfunction
  initial begin
    miso = 1'b0;
    rx = 8'h00;
    sh = 8'h00;
    n = 0;
  end
  always @(negedge ss_n) begin
    n = 0;
    if (!clock_phase) miso = pick(0);
  end
  // released line must not keep looking valid
  always @(posedge ss_n) miso = ~miso;
  always @(sck) begin
    if (!ss_n && ((sck !== clock_polarity) == !clock_phase)) begin
      sh = lsb ? {mosi, sh[7:1]} : {sh[6:0], mosi};
      n = n + 1;
      if (n == 8) rx = sh;
    end else if (!ss_n && n < 8) begin
      miso = pick(n);
    end
  end
endmodule

// ---- sim/test_spi_port.sv ----
/* self-checking bench: apb master, far-side slave model, bench master for
   slave mode. assumes zero-wait apb and pins resolved here. */
`timescale 1ns/100ps
module test_spi_port;
  import spi_pkg::*;
  logic mclk, rstn, psel, penable, pwrite, gie, irq_ack, pready, pslverr, port_irq;
  logic [7:0] paddr, p_tx, p_rx;
  logic [31:0] pwdata, prdata;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe;
  logic b_sck, b_mosi, b_ss, p_miso, clock_polarity, clock_phase, lsb;
  wire sck_w = sck_oe ? sck_o : b_sck;
  wire mosi_w = mosi_oe ? mosi_o : b_mosi;
  wire miso_w = miso_oe ? miso_o : p_miso;
  wire ss_w = ss_n_oe ? ss_n_o : b_ss;
  int fail_count, n_checks;
  logic [15:0] seed;
  int divs [0:7] = '{4, 16, 64, 128, 2, 8, 32, 64};
  spi_port u_spi_port (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gie(gie), .irq_ack(irq_ack), .port_irq(port_irq),
    .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe),
    .ss_n_i(ss_w), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe));
  spi_partner u_spi_partner (.sck(sck_w), .ss_n(ss_w), .mosi(mosi_w), .clock_polarity(clock_polarity),
    .clock_phase(clock_phase), .lsb(lsb), .tx(p_tx), .miso(p_miso), .rx(p_rx));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // called just after a rising edge; leaves one idle cycle behind
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for pready
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, {seed, 8'h00, d}, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic wait_done();
    logic [31:0] q;
    int k;
    k = 0;
    do begin
      rd(ADDR_STATUS, q);
      k++;
    end while (q[STS_DONE] !== 1'b1 && k < 600);
    chk("status_done", 32'h80, q & 32'hffffffbe);
  endtask
  // master byte: measures one sck half period, returns the read-back byte
  task automatic mxfer(input logic [7:0] ctl, input logic [7:0] d, output int half,
                       output logic [31:0] q);
    int c;
    logic [31:0] s;
    clock_polarity = ctl[CTL_CLOCK_POLARITY];
    clock_phase = ctl[CTL_CLOCK_PHASE];
    lsb = ctl[CTL_ORDER];
    seed = lfsr(seed);
    p_tx = seed[15:8];
    wr(ADDR_CONTROL, ctl);
    wr(ADDR_PIN_DIR, 8'h0d);
    wr(ADDR_DATA, d);
    c = 0;
    while (sck_o === clock_polarity && c < 300) begin
      @(negedge mclk);
      c++;
    end
    half = 0;
    while (sck_o !== clock_polarity && half < 300) begin
      @(negedge mclk);
      half++;
    end
    @(posedge mclk);
    wait_done();
    chk("sck_idle", clock_polarity, sck_o);
    rd(ADDR_DATA, q);
    rd(ADDR_STATUS, s);
    chk("done_clear", 32'h0, s & 32'hc0);
    wr(ADDR_PIN_DIR, 8'h1d);
  endtask
  // bench master for slave mode in the clock_polarity, clock_phase, lsb setting, sck at mclk/16
  task automatic smaster(input logic [7:0] d, input int nb, output logic [7:0] g);
    b_sck <= clock_polarity;
    repeat (8) @(posedge mclk);
    b_ss <= 1'b0;
    repeat (8) @(posedge mclk);
    for (int i = 0; i < nb; i++) begin
      if (clock_phase) begin
        b_sck <= !clock_polarity;
      end
      b_mosi <= lsb ? d[i] : d[7 - i];
      repeat (8) @(posedge mclk);
      g = lsb ? {miso_w, g[7:1]} : {g[6:0], miso_w};
      b_sck <= clock_phase ? clock_polarity : !clock_polarity;
      repeat (8) @(posedge mclk);
      if (!clock_phase) begin
        b_sck <= clock_polarity;
      end
    end
    repeat (8) @(posedge mclk);
    b_ss <= 1'b1;
    b_mosi <= ~b_mosi;
    repeat (8) @(posedge mclk);
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    fail_count++;
    report_and_stop();
  end
  initial begin
    logic [31:0] q;
    logic e;
    logic [7:0] d, g;
    int half;
    {psel, penable, pwrite, gie, irq_ack, b_sck, b_mosi, clock_polarity, clock_phase, lsb} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    p_tx = 8'h00;
    b_ss = 1'b1;
    fail_count = 0;
    n_checks = 0;
    seed = 16'd2208;
    rstn = 1'b0;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rd(ADDR_CONTROL, q);
    chk("control_rst", 32'h0, q);
    rd(ADDR_PIN_DIR, q);
    chk("pin_dir_rst", 32'h10, q);
    apb(1'b0, 8'h10, 32'h0, q, e);
    chk("unmapped_rd", 32'h0, q);
    chk("unmapped_err", 32'h1, e);
    wr(ADDR_CONTROL, 8'h10);
    wr(ADDR_PIN_DIR, 8'h0d);
    wr(ADDR_DATA, 8'h5a);
    repeat (40) @(posedge mclk);
    rd(ADDR_STATUS, q);
    chk("off_done", 32'h0, q & 32'hc0);
    chk("off_sck_oe", 32'h0, sck_oe);
    wr(ADDR_PIN_DIR, 8'h1d);
    $display("test reset and disabled end");
    for (int m = 0; m < 8; m++) begin
      seed = lfsr(seed);
      d = seed[7:0];
      mxfer(8'h51 | {2'b0, m[2], 1'b0, m[1:0], 2'b0}, d, half, q);
      chk("master_rx", p_tx, q);
      chk("far_rx", d, p_rx);
      chk("half_16", 32'd8, half);
    end
    $display("test modes end");
    for (int r = 0; r < 8; r++) begin
      wr(ADDR_STATUS, {7'h0, r[2]});
      mxfer({6'h14, r[1:0]}, 8'ha5, half, q);
      chk("half_rate", divs[r] / 2, half);
    end
    wr(ADDR_STATUS, 8'h00);
    $display("test rates end");
    {clock_polarity, clock_phase, lsb} = 3'b000;
    wr(ADDR_CONTROL, 8'h53);
    wr(ADDR_PIN_DIR, 8'h0d);
    wr(ADDR_DATA, 8'h3c);
    wr(ADDR_DATA, 8'hc3);
    rd(ADDR_STATUS, q);
    chk("write_collision_flag_set", 32'h40, q & 32'hc0);
    wait_done();
    rd(ADDR_DATA, q);
    rd(ADDR_STATUS, q);
    chk("write_collision_flag_clear", 32'h0, q & 32'hc0);
    chk("tx_kept", 32'h3c, p_rx);
    wr(ADDR_PIN_DIR, 8'h1d);
    $display("test collision end");
    gie <= 1'b1;
    wr(ADDR_CONTROL, 8'hd0);
    wr(ADDR_PIN_DIR, 8'h05);
    b_ss <= 1'b0;
    repeat (10) @(posedge mclk);
    rd(ADDR_CONTROL, q);
    chk("master_lost", 32'hc0, q);
    chk("irq_loss", 32'h1, port_irq);
    gie <= 1'b0;
    @(posedge mclk);
    chk("irq_masked", 32'h0, port_irq);
    gie <= 1'b1;
    irq_ack <= 1'b1;
    @(posedge mclk);
    irq_ack <= 1'b0;
    @(posedge mclk);
    chk("irq_ack", 32'h0, port_irq);
    b_ss <= 1'b1;
    repeat (20) @(posedge mclk);
    rd(ADDR_CONTROL, q);
    chk("master_stays", 32'hc0, q);
    $display("test loss of master end");
    wr(ADDR_CONTROL, 8'h43);
    wr(ADDR_PIN_DIR, 8'h1f);
    chk("slave_pins_in", 32'h0, {sck_oe, mosi_oe, ss_n_oe});
    wr(ADDR_DATA, 8'h96);
    smaster(8'h0f, 3, g);
    chk("miso_off", 32'h0, miso_oe);
    rd(ADDR_STATUS, q);
    chk("partial_nodone", 32'h0, q & 32'hc0);
    wr(ADDR_DATA, 8'h96);
    seed = lfsr(seed);
    d = seed[7:0];
    smaster(d, 8, g);
    chk("slave_tx", 32'h96, g);
    wait_done();
    rd(ADDR_DATA, q);
    chk("slave_rx", d, q);
    {clock_polarity, clock_phase, lsb} = 3'b111;
    wr(ADDR_CONTROL, 8'h6f);
    seed = lfsr(seed);
    wr(ADDR_DATA, seed[15:8]);
    d = seed[7:0];
    smaster(d, 8, g);
    chk("slave_tx_m3", {24'h0, seed[15:8]}, g);
    wait_done();
    rd(ADDR_DATA, q);
    chk("slave_rx_m3", d, q);
    $display("test slave end");
    report_and_stop();
  end
endmodule
